// [rtl/tmc_pkg.sv]
package tmc_pkg;
  localparam logic [7:0]  TMC_MODE_OFS   = 8'h00;
  localparam logic [7:0]  TMC_CAP0_OFS   = 8'h04;
  localparam logic [7:0]  TMC_CAP1_OFS   = 8'h08;
  localparam logic [7:0]  TMC_CMP1_OFS   = 8'h0c;
  localparam logic [7:0]  TMC_RUN_OFS    = 8'h10;
  localparam logic [7:0]  TMC_CNT_OFS    = 8'h14;
  localparam int          TMC_SWCAP_BIT  = 6;
  localparam int          TMC_CPM_LSB    = 4;
  localparam int          TMC_CLE_BIT    = 3;
  localparam int          TMC_CLK_LSB    = 0;
  localparam logic [1:0]  TMC_CPM_RST    = 2'h0;
  localparam logic [2:0]  TMC_CLK_RST    = 3'h0;
  localparam logic [15:0] TMC_CMP1_RST   = 16'hffff;
  localparam logic [7:0]  TMC_PRE_RST    = 8'h00;

  typedef enum logic [1:0] {
    TMC_CPM_OFF  = 2'h0,
    TMC_CPM_IN01 = 2'h1,
    TMC_CPM_IN0  = 2'h2,
    TMC_CPM_EXT  = 2'h3
  } tmc_cpm_e;

  typedef enum logic [2:0] {
    TMC_CLK_PIN  = 3'h0,
    TMC_CLK_D1   = 3'h1,
    TMC_CLK_D4   = 3'h2,
    TMC_CLK_D16  = 3'h3,
    TMC_CLK_D32  = 3'h4,
    TMC_CLK_D64  = 3'h5,
    TMC_CLK_D128 = 3'h6,
    TMC_CLK_D256 = 3'h7
  } tmc_clk_e;
endpackage

// [rtl/tmc_timer.sv]
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R01 - Writing zero to sw_capture_trigger loads capture_reg_0
// R02 - Edge select 00 disables hardware captures
// R03 - Select 01: input0 rise, input1 rise
// R04 - Select 10: input0 rise and fall
// R05 - Select 11: other channel match output edges
// R06 - Software never programs 11 on channels 7-9
// R07 - match1_clear_enable clears counter on compare match
// R08 - source_clock_select picks pin or prescaler tap
// R09 - Software stops channel before changing mode
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int CHANNEL_ID = 0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_input_0,
  input  wire logic        ext_input_1,
  input  wire logic        other_match_output,
  output logic             channel_match_output
);

  typedef struct packed {
    logic [2:0]  in0_sync;
    logic [2:0]  in1_sync;
    logic [2:0]  oth_sync;
    logic [1:0]  cpm;
    logic        cle;
    logic [2:0]  clk_sel;
    logic        run;
    logic [7:0]  pre;
    logic [15:0] cnt;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic [15:0] cmp1;
    logic        match_out;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } tmc_state_s;

  tmc_state_s st_reg;
  tmc_state_s st_next;

  logic       wr;
  logic       in0_rise;
  logic       in0_fall;
  logic       in1_rise;
  logic       oth_rise;
  logic       oth_fall;
  logic       ext_ok;
  logic       tick;
  logic       match1;
  logic       swcap;
  logic       hw_cap0;
  logic       hw_cap1;
  logic       mapped;
  logic [31:0] rd_val;

  assign prdata               = st_reg.rdata;
  assign pready               = st_reg.ready;
  assign pslverr              = st_reg.err;
  assign channel_match_output = st_reg.match_out;

  assign wr       = psel & penable & st_reg.ready & pwrite;
  assign in0_rise = st_reg.in0_sync[1] & ~st_reg.in0_sync[2];
  assign in0_fall = ~st_reg.in0_sync[1] & st_reg.in0_sync[2];
  assign in1_rise = st_reg.in1_sync[1] & ~st_reg.in1_sync[2];
  assign oth_rise = st_reg.oth_sync[1] & ~st_reg.oth_sync[2];
  assign oth_fall = ~st_reg.oth_sync[1] & st_reg.oth_sync[2];
  // Channels 7 to 9 have no source channel for select 11
  assign ext_ok   = !(CHANNEL_ID inside {7, 8, 9}); // see R06
  assign match1   = st_reg.run & (st_reg.cnt == st_reg.cmp1);
  assign swcap    = wr & (paddr == TMC_MODE_OFS) & ~pwdata[TMC_SWCAP_BIT]; // see R01

  // Count clock selection
  always_comb begin
    unique case (tmc_clk_e'(st_reg.clk_sel))
      TMC_CLK_PIN:  tick = in0_rise; // see R08
      TMC_CLK_D1:   tick = 1'b1;
      TMC_CLK_D4:   tick = &st_reg.pre[1:0];
      TMC_CLK_D16:  tick = &st_reg.pre[3:0];
      TMC_CLK_D32:  tick = &st_reg.pre[4:0];
      TMC_CLK_D64:  tick = &st_reg.pre[5:0];
      TMC_CLK_D128: tick = &st_reg.pre[6:0];
      TMC_CLK_D256: tick = &st_reg.pre[7:0];
    endcase
  end

  // Hardware capture triggers
  always_comb begin
    unique case (tmc_cpm_e'(st_reg.cpm))
      TMC_CPM_OFF: begin
        hw_cap0 = 1'b0; // see R02
        hw_cap1 = 1'b0;
      end
      TMC_CPM_IN01: begin
        hw_cap0 = in0_rise; // see R03
        hw_cap1 = in1_rise;
      end
      TMC_CPM_IN0: begin
        hw_cap0 = in0_rise; // see R04
        hw_cap1 = in0_fall;
      end
      TMC_CPM_EXT: begin
        hw_cap0 = oth_rise & ext_ok; // see R05
        hw_cap1 = oth_fall & ext_ok;
      end
    endcase
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      TMC_MODE_OFS: rd_val = {24'h000000, 1'b0, 1'b1, st_reg.cpm, st_reg.cle, st_reg.clk_sel};
      TMC_CAP0_OFS: rd_val = {16'h0000, st_reg.cap0};
      TMC_CAP1_OFS: rd_val = {16'h0000, st_reg.cap1};
      TMC_CMP1_OFS: rd_val = {16'h0000, st_reg.cmp1};
      TMC_RUN_OFS:  rd_val = {31'h00000000, st_reg.run};
      TMC_CNT_OFS:  rd_val = {16'h0000, st_reg.cnt};
      default:      mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.in0_sync = {st_reg.in0_sync[1:0], ext_input_0};
    st_next.in1_sync = {st_reg.in1_sync[1:0], ext_input_1};
    st_next.oth_sync = {st_reg.oth_sync[1:0], other_match_output};
    // No wait state; pready is registered from the setup phase
    st_next.ready = psel & ~penable & ~st_reg.ready;
    st_next.err   = psel & ~penable & ~st_reg.ready & ~mapped;
    if (psel & ~penable & ~st_reg.ready) begin
      st_next.rdata = rd_val;
    end
    // Counter and prescaler, stop clears both
    if (!st_reg.run) begin
      st_next.pre = TMC_PRE_RST;
      st_next.cnt = 16'h0000;
    end else begin
      st_next.pre = st_reg.pre + 8'h01;
      if (tick) begin
        if (st_reg.cle && match1) begin
          st_next.cnt = 16'h0000; // see R07
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
    end
    if (match1 && tick) begin
      st_next.match_out = ~st_reg.match_out;
    end
    if (swcap || hw_cap0) begin
      st_next.cap0 = st_reg.cnt; // see R01
    end
    if (hw_cap1) begin
      st_next.cap1 = st_reg.cnt;
    end
    // Register writes; mode changes while running are the software's concern
    if (wr) begin
      unique case (paddr)
        TMC_MODE_OFS: begin
          st_next.cpm     = pwdata[TMC_CPM_LSB +: 2];
          st_next.cle     = pwdata[TMC_CLE_BIT];
          st_next.clk_sel = pwdata[TMC_CLK_LSB +: 3]; // see R09
        end
        TMC_CMP1_OFS: st_next.cmp1 = pwdata[15:0];
        TMC_RUN_OFS:  st_next.run  = pwdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.cpm     <= TMC_CPM_RST;
      st_reg.clk_sel <= TMC_CLK_RST;
      st_reg.cmp1    <= TMC_CMP1_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sw_capture;
    swcap |=> st_reg.cap0 == $past(st_reg.cnt);
  endproperty
  a_sw_capture: assert property (p_sw_capture) else $error("sw capture missed"); // see R01

  property p_cpm_off;
    (st_reg.cpm == 2'h0) && !swcap |=> $stable(st_reg.cap0) && $stable(st_reg.cap1);
  endproperty
  a_cpm_off: assert property (p_cpm_off) else $error("capture while disabled"); // see R02

  property p_in01;
    (st_reg.cpm == 2'h1) && (st_reg.in1_sync[1] && !st_reg.in1_sync[2])
      |=> st_reg.cap1 == $past(st_reg.cnt);
  endproperty
  a_in01: assert property (p_in01) else $error("input1 rise not captured"); // see R03

  property p_in0_both;
    (st_reg.cpm == 2'h2) && (!st_reg.in0_sync[1] && st_reg.in0_sync[2])
      |=> st_reg.cap1 == $past(st_reg.cnt);
  endproperty
  a_in0_both: assert property (p_in0_both) else $error("input0 fall not captured"); // see R04

  property p_ext_src;
    (st_reg.cpm == 2'h3) && ext_ok && (st_reg.oth_sync[1] && !st_reg.oth_sync[2])
      |=> st_reg.cap0 == $past(st_reg.cnt);
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("source rise not captured"); // see R05

  property p_ext_block;
    (st_reg.cpm == 2'h3) && !ext_ok |-> !hw_cap0 && !hw_cap1;
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("illegal source used"); // see R06

  property p_clear;
    st_reg.run && st_reg.cle && match1 && tick && !wr |=> st_reg.cnt == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("match clear missed"); // see R07

  property p_no_clear;
    st_reg.run && !st_reg.cle && tick && !wr |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("count step wrong"); // see R07

  property p_div4;
    st_reg.run && (st_reg.clk_sel == 3'h2) && !wr && !(st_reg.cle && match1)
      |=> (st_reg.cnt != $past(st_reg.cnt)) == ($past(st_reg.pre[1:0]) == 2'h3);
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 wrong"); // see R08

endmodule // tmc_timer
`default_nettype wire

// [tb/tmc_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
  input  wire logic pclk,
  output logic      pin0,
  output logic      pin1,
  output logic      pin_other
);
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
    pin_other = 1'b0;
  end
  // Level held past the synchroniser
  task automatic drive(input int k, input logic v);
    @(posedge pclk);
    if (k == 0)
      pin0 <= v;
    else if (k == 1)
      pin1 <= v;
    else
      pin_other <= v;
    repeat (6) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    drive(k, 1'b1);
    drive(k, 1'b0);
  endtask
endmodule // tmc_pin_model
`default_nettype wire

// [tb/test_timer_mode_capture_config.sv]
`timescale 1ns/100ps
`default_nettype none
module test_timer_mode_capture_config;
  import tmc_pkg::*;
  typedef struct {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic se;
  } tmc_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, in0, in1, oth, err, mo;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [8:0]  step [1:7] = '{9'h100, 9'h40, 9'h10, 9'h8, 9'h4, 9'h2, 9'h1};
  int          num_errors, n_compared;
  int          cycles = 0;
  tmc_row_s rows [14] = '{
    '{1'h0, TMC_MODE_OFS, 32'h0, 32'h40, 1'h0},
    '{1'h0, TMC_CMP1_OFS, 32'h0, 32'hffff, 1'h0},
    '{1'h0, TMC_RUN_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h0, TMC_CNT_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h0, TMC_CAP0_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h0, TMC_CAP1_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h1, TMC_CMP1_OFS, 32'hffff1234, 32'h0, 1'h0},
    '{1'h0, TMC_CMP1_OFS, 32'h0, 32'h1234, 1'h0},
    '{1'h1, TMC_CAP0_OFS, 32'habcd, 32'h0, 1'h0},
    '{1'h0, TMC_CAP0_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h1, TMC_MODE_OFS, 32'h7f, 32'h0, 1'h0},
    '{1'h0, TMC_MODE_OFS, 32'h0, 32'h7f, 1'h0},
    '{1'h1, 8'h20, 32'h1, 32'h0, 1'h1},
    '{1'h0, 8'h20, 32'h0, 32'h0, 1'h1}};
  tmc_timer #(.CHANNEL_ID(0)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_input_0(in0), .ext_input_1(in1), .other_match_output(oth),
    .channel_match_output(mo));
  tmc_pin_model ext (.pclk(pclk), .pin0(in0), .pin1(in1), .pin_other(oth));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("Errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait, or the bench timeout if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Stop, reprogram, restart
  task automatic setm(input logic [31:0] m);
    apb(1'b1, TMC_RUN_OFS, 32'h0);
    apb(1'b1, TMC_MODE_OFS, m);
    apb(1'b1, TMC_RUN_OFS, 32'h1);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(rd, rows[i].e);
      chk({31'h0, err}, {31'h0, rows[i].se});
    end
    setm(32'h40);
    repeat (3) ext.pulse(0);
    rchk(TMC_CNT_OFS, 32'h3);
    apb(1'b1, TMC_MODE_OFS, 32'h0);
    rchk(TMC_CAP0_OFS, 32'h3);
    apb(1'b1, TMC_MODE_OFS, 32'h40);
    repeat (2) ext.pulse(0);
    ext.pulse(1);
    ext.pulse(2);
    rchk(TMC_CAP0_OFS, 32'h3);
    rchk(TMC_CAP1_OFS, 32'h0);
    setm(32'h50);
    repeat (2) ext.pulse(0);
    ext.pulse(1);
    rchk(TMC_CAP0_OFS, 32'h1);
    rchk(TMC_CAP1_OFS, 32'h2);
    setm(32'h60);
    repeat (3) ext.pulse(0);
    rchk(TMC_CAP0_OFS, 32'h2);
    rchk(TMC_CAP1_OFS, 32'h3);
    setm(32'h70);
    repeat (4) ext.pulse(0);
    ext.drive(2, 1'b1);
    ext.pulse(0);
    ext.drive(2, 1'b0);
    rchk(TMC_CAP0_OFS, 32'h4);
    rchk(TMC_CAP1_OFS, 32'h5);
    apb(1'b1, TMC_CMP1_OFS, 32'h2);
    setm(32'h48);
    repeat (3) ext.pulse(0);
    rchk(TMC_CNT_OFS, 32'h0);
    chk({31'h0, mo}, 32'h1);
    setm(32'h40);
    repeat (3) ext.pulse(0);
    rchk(TMC_CNT_OFS, 32'h3);
    chk({31'h0, mo}, 32'h0);
    for (int c = 1; c < 8; c++) begin
      setm(32'h40 | {29'h0, c[2:0]});
      apb(1'b0, TMC_CNT_OFS, 32'h0);
      v = rd;
      repeat (253) @(posedge pclk);
      rchk(TMC_CNT_OFS, (v + {23'h0, step[c]}) & 32'hffff);
    end
    // Mid-run reset, then every register at its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, mo}, 32'h0);
    presetn <= 1'b1;
    rchk(TMC_MODE_OFS, 32'h40);
    rchk(TMC_CMP1_OFS, 32'hffff);
    rchk(TMC_RUN_OFS, 32'h0);
    rchk(TMC_CNT_OFS, 32'h0);
    rchk(TMC_CAP0_OFS, 32'h0);
    rchk(TMC_CAP1_OFS, 32'h0);
    close_out();
  end
endmodule // test_timer_mode_capture_config
`default_nettype wire
